/* File: hw/conversion_timer.sv */
// Purpose: Millisecond timer for start-up, soft reset and conversions
// Assumes: CYCLES_PER_MS below 65536
// Notes:   Busy for the start-up time straight out of reset
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"
module conversion_timer #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [6:0] i_ticks,
  output logic o_busy,
  output logic o_done
);
  logic [15:0] div_ff;
  logic [6:0] left_ff;
  logic busy_ff;
  logic [15:0] nxt_div;
  logic [6:0] nxt_left;
  logic nxt_busy;
  logic ms_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Divider restarts with each start so the wait is whole milliseconds
  always_comb
  begin
    ms_tick = (div_ff == 16'(CYCLES_PER_MS - 1));
    nxt_div = ms_tick ? 16'h0000 : div_ff + 16'h0001;
    nxt_left = left_ff;
    nxt_busy = busy_ff;
    o_done = 1'b0;
    if (i_start)
    begin
      nxt_div = 16'h0000;
      nxt_left = i_ticks;
      nxt_busy = 1'b1;
    end
    else if (busy_ff && ms_tick)
    begin
      nxt_left = left_ff - 7'h01;
      if (left_ff == 7'h01)
      begin
        nxt_busy = 1'b0;
        o_done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      div_ff <= 16'h0000;
      left_ff <= 7'(`STARTUP_MS);
      busy_ff <= 1'b1;
    end
    else
    begin
      div_ff <= nxt_div;
      left_ff <= nxt_left;
      busy_ff <= nxt_busy;
    end
  end

  assign o_busy = busy_ff;
endmodule // conversion_timer
`default_nettype wire

/* File: hw/humidity_temp_i2c_command_slave.sv */
// Purpose: Two-wire command slave of a humidity and temperature sensor
// Assumes: Host keeps SCL low and high for several core clocks each
// Notes:   Conversion value comes from the analog front end on i_conv_result
`timescale 1ns/1ps
`default_nettype none
`include "sensor_consts.svh"
module humidity_temp_i2c_command_slave #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_low_supply,
  input wire logic [13:0] i_conv_result,
  output logic o_conv_busy,
  output logic o_conv_humidity,
  output logic o_heater_en
);
  link_events_if lnk();

  sensor_pkg::state_t state_ff;
  sensor_pkg::state_t nxt_state;
  sensor_pkg::purpose_t purpose_ff;
  sensor_pkg::purpose_t nxt_purpose;
  sensor_pkg::rd_src_t rd_src_ff;
  sensor_pkg::rd_src_t nxt_rd_src;
  logic [3:0] bitcnt_ff;
  logic [3:0] nxt_bitcnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [1:0] byte_idx_ff;
  logic [1:0] nxt_byte_idx;
  logic is_read_ff;
  logic nxt_is_read;
  logic meas_run_ff;
  logic nxt_meas_run;
  logic meas_hold_ff;
  logic nxt_meas_hold;
  logic meas_humid_ff;
  logic nxt_meas_humid;
  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic [15:0] result_ff;
  logic [15:0] nxt_result;
  logic [7:0] crc_ff;
  logic [7:0] nxt_crc;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic scl_oe_ff;
  logic nxt_scl_oe;
  logic [1:0] low_sync_ff;
  logic ack;
  logic addr_hit;
  logic tmr_start;
  logic [6:0] tmr_ticks;
  logic tmr_busy;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[7] ^ d[i];
      r = {r[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
    end
    return r;
  endfunction

  function automatic logic [6:0] meas_ticks(input logic [1:0] res, input logic humid);
    logic [6:0] t;
    case (res)
      2'h0: t = humid ? 7'(`H12_MS) : 7'(`T14_MS);
      2'h1: t = humid ? 7'(`H8_MS) : 7'(`T12_MS);
      2'h2: t = humid ? 7'(`H10_MS) : 7'(`T13_MS);
      default: t = humid ? 7'(`H11_MS) : 7'(`T11_MS);
    endcase
    return t;
  endfunction

  // Defaults with the heater left as it stands
  function automatic logic [7:0] cfg_default(input logic [7:0] cur);
    logic [7:0] r;
    r = `CFG_RESET;
    r[`CFG_HEATER] = cur[`CFG_HEATER];
    return r;
  endfunction

  function automatic logic [7:0] tx_byte(input sensor_pkg::rd_src_t src, input logic [1:0] idx,
    input logic [15:0] res, input logic [7:0] crc, input logic [7:0] cfg);
    logic [7:0] b;
    if (src == sensor_pkg::SRC_REG)
      b = cfg;
    else if (idx == 2'h0)
      b = res[15:8];
    else if (idx == 2'h1)
      b = res[7:0];
    else
      b = crc;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  line_sampler u_line (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .lnk(lnk.drv)
  );

  conversion_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(tmr_start),
    .i_ticks(tmr_ticks),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state = state_ff;
    nxt_purpose = purpose_ff;
    nxt_rd_src = rd_src_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_is_read = is_read_ff;
    nxt_meas_run = meas_run_ff;
    nxt_meas_hold = meas_hold_ff;
    nxt_meas_humid = meas_humid_ff;
    nxt_cfg = cfg_ff;
    nxt_result = result_ff;
    nxt_crc = crc_ff;
    tmr_start = 1'b0;
    tmr_ticks = 7'h00;
    ack = 1'b0;
    // Start-up or soft reset still running keeps the slave deaf
    addr_hit = (shift_ff[7:1] == `I2C_ADDR) && !(tmr_busy && !meas_run_ff);
    if (tmr_done && meas_run_ff)
    begin
      nxt_meas_run = 1'b0;
      nxt_result = {i_conv_result, meas_humid_ff, 1'b0};
      nxt_crc = crc8(crc8(`CRC_INIT, nxt_result[15:8]), nxt_result[7:0]);
      nxt_cfg[`CFG_LOW_SUPPLY] = low_sync_ff[1];
    end
    if (lnk.stop)
      nxt_state = sensor_pkg::ST_IDLE;
    else if (lnk.start)
    begin
      nxt_state = sensor_pkg::ST_RX;
      nxt_purpose = sensor_pkg::P_ADDR;
      nxt_bitcnt = 4'h0;
    end
    else
    begin
      case (state_ff)
        sensor_pkg::ST_RX:
        begin
          if (lnk.scl_rise && bitcnt_ff != 4'h8)
          begin
            nxt_shift = {shift_ff[6:0], lnk.sda};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
          else if (lnk.scl_fall && bitcnt_ff == 4'h8)
          begin
            case (purpose_ff)
              sensor_pkg::P_ADDR:
              begin
                nxt_is_read = shift_ff[0];
                if (addr_hit && !shift_ff[0])
                  ack = 1'b1;
                else if (addr_hit && rd_src_ff == sensor_pkg::SRC_REG)
                  ack = 1'b1;
                else if (addr_hit && rd_src_ff == sensor_pkg::SRC_MEAS)
                  ack = !meas_run_ff || meas_hold_ff;
              end
              sensor_pkg::P_CMD:
              begin
                case (shift_ff)
                  `CMD_T_HOLD, `CMD_RH_HOLD, `CMD_T_POLL, `CMD_RH_POLL:
                  begin
                    ack = 1'b1;
                    nxt_meas_humid = shift_ff[2];
                    nxt_meas_hold = !shift_ff[4];
                    if (!cfg_ff[`CFG_NO_RELOAD])
                      nxt_cfg = cfg_default(cfg_ff);
                    tmr_start = 1'b1;
                    tmr_ticks = meas_ticks({nxt_cfg[`CFG_RES_HI], nxt_cfg[`CFG_RES_LO]},
                      shift_ff[2]);
                    nxt_meas_run = 1'b1;
                    nxt_rd_src = sensor_pkg::SRC_MEAS;
                  end
                  `CMD_WR_CFG:
                  begin
                    ack = 1'b1;
                    nxt_purpose = sensor_pkg::P_WDATA;
                  end
                  `CMD_RD_CFG:
                  begin
                    ack = 1'b1;
                    nxt_rd_src = sensor_pkg::SRC_REG;
                  end
                  `CMD_SOFT_RST:
                  begin
                    ack = 1'b1;
                    nxt_cfg = cfg_default(cfg_ff);
                    tmr_start = 1'b1;
                    tmr_ticks = 7'(`SOFT_RESET_MS - 1);
                    nxt_meas_run = 1'b0;
                    nxt_rd_src = sensor_pkg::SRC_NONE;
                  end
                  default: ack = 1'b0;
                endcase
              end
              sensor_pkg::P_WDATA:
              begin
                ack = 1'b1;
                // Low-supply flag cannot be written; reserved bits take what host sends
                // Flag taken from nxt_cfg so a capture in this cycle is not lost
                nxt_cfg = {shift_ff[7], nxt_cfg[`CFG_LOW_SUPPLY], shift_ff[5:0]};
                nxt_purpose = sensor_pkg::P_DONE;
              end
              default: ack = 1'b0;
            endcase
            nxt_state = ack ? sensor_pkg::ST_ACK : sensor_pkg::ST_IDLE;
          end
        end
        sensor_pkg::ST_ACK:
        begin
          if (lnk.scl_fall)
          begin
            nxt_bitcnt = 4'h0;
            nxt_byte_idx = 2'h0;
            if (purpose_ff == sensor_pkg::P_ADDR && is_read_ff)
            begin
              if (meas_run_ff && rd_src_ff == sensor_pkg::SRC_MEAS)
                nxt_state = sensor_pkg::ST_STRETCH;
              else
              begin
                nxt_state = sensor_pkg::ST_TX;
                nxt_shift = tx_byte(rd_src_ff, 2'h0, result_ff, crc_ff, cfg_ff);
              end
            end
            else if (purpose_ff == sensor_pkg::P_ADDR)
            begin
              nxt_state = sensor_pkg::ST_RX;
              nxt_purpose = sensor_pkg::P_CMD;
            end
            else if (purpose_ff == sensor_pkg::P_WDATA)
              nxt_state = sensor_pkg::ST_RX;
            else
              nxt_state = sensor_pkg::ST_IDLE;
          end
        end
        sensor_pkg::ST_STRETCH:
        begin
          // Clock held low until the result is captured
          if (!meas_run_ff)
          begin
            nxt_state = sensor_pkg::ST_TX;
            nxt_shift = tx_byte(rd_src_ff, 2'h0, result_ff, crc_ff, cfg_ff);
          end
        end
        sensor_pkg::ST_TX:
        begin
          if (lnk.scl_fall && bitcnt_ff == 4'h7)
          begin
            nxt_state = sensor_pkg::ST_HACK;
            nxt_bitcnt = 4'h0;
          end
          else if (lnk.scl_fall)
          begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
        end
        sensor_pkg::ST_HACK:
        begin
          if (lnk.scl_rise && lnk.sda)
            nxt_state = sensor_pkg::ST_IDLE;
          else if (lnk.scl_rise)
            nxt_bitcnt = 4'h1;
          else if (lnk.scl_fall && bitcnt_ff == 4'h1)
          begin
            nxt_bitcnt = 4'h0;
            if (rd_src_ff == sensor_pkg::SRC_MEAS && byte_idx_ff != 2'h2)
            begin
              nxt_byte_idx = byte_idx_ff + 2'h1;
              nxt_state = sensor_pkg::ST_TX;
              nxt_shift = tx_byte(rd_src_ff, nxt_byte_idx, result_ff, crc_ff, cfg_ff);
            end
            else
              nxt_state = sensor_pkg::ST_IDLE;
          end
        end
        default: nxt_state = sensor_pkg::ST_IDLE;
      endcase
    end
    nxt_sda_oe = (nxt_state == sensor_pkg::ST_ACK) ||
      (nxt_state == sensor_pkg::ST_TX && !nxt_shift[7]);
    nxt_scl_oe = (nxt_state == sensor_pkg::ST_STRETCH);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_ff <= sensor_pkg::ST_IDLE;
      purpose_ff <= sensor_pkg::P_ADDR;
      rd_src_ff <= sensor_pkg::SRC_NONE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byte_idx_ff <= 2'h0;
      is_read_ff <= 1'b0;
      meas_run_ff <= 1'b0;
      meas_hold_ff <= 1'b0;
      meas_humid_ff <= 1'b0;
      cfg_ff <= `CFG_RESET;
      result_ff <= 16'h0000;
      crc_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      low_sync_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      purpose_ff <= nxt_purpose;
      rd_src_ff <= nxt_rd_src;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      byte_idx_ff <= nxt_byte_idx;
      is_read_ff <= nxt_is_read;
      meas_run_ff <= nxt_meas_run;
      meas_hold_ff <= nxt_meas_hold;
      meas_humid_ff <= nxt_meas_humid;
      cfg_ff <= nxt_cfg;
      result_ff <= nxt_result;
      crc_ff <= nxt_crc;
      sda_oe_ff <= nxt_sda_oe;
      scl_oe_ff <= nxt_scl_oe;
      low_sync_ff <= {low_sync_ff[0], i_low_supply};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain pins: only ever pull low
  assign o_sda_out = 1'b0;
  assign o_scl_out = 1'b0;
  assign o_sda_oe = sda_oe_ff;
  assign o_scl_oe = scl_oe_ff;
  assign o_conv_busy = meas_run_ff;
  assign o_conv_humidity = meas_humid_ff;
  assign o_heater_en = cfg_ff[`CFG_HEATER];
endmodule // humidity_temp_i2c_command_slave
`default_nettype wire

/* File: hw/line_sampler.sv */
// Purpose: Synchronise SCL and SDA and find edges, start and stop
// Assumes: Core clock much faster than SCL
// Notes:   First flop of each chain feeds only the second
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  link_events_if.drv lnk
);
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic [1:0] nxt_scl_sync;
  logic [1:0] nxt_sda_sync;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_scl_sync = {scl_sync_ff[0], i_scl};
    nxt_sda_sync = {sda_sync_ff[0], i_sda};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= nxt_scl_sync;
      sda_sync_ff <= nxt_sda_sync;
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA moving while SCL stays high marks start or stop
  assign lnk.scl = scl_sync_ff[1];
  assign lnk.sda = sda_sync_ff[1];
  assign lnk.scl_rise = scl_sync_ff[1] && !scl_prev_ff;
  assign lnk.scl_fall = !scl_sync_ff[1] && scl_prev_ff;
  assign lnk.start = scl_sync_ff[1] && scl_prev_ff && sda_prev_ff && !sda_sync_ff[1];
  assign lnk.stop = scl_sync_ff[1] && scl_prev_ff && !sda_prev_ff && sda_sync_ff[1];
endmodule // line_sampler
`default_nettype wire

/* File: hw/link_events_if.sv */
// Purpose: Sampled bus levels and events passed to the command logic
// Assumes: All signals on the core clock
// Notes:   Events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface link_events_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport drv (output scl, output sda, output scl_rise, output scl_fall, output start,
    output stop);
  modport mon (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface
`default_nettype wire

/* File: hw/sensor_consts.svh */
// Purpose: Constants of the humidity and temperature command slave
// Assumes: 25 MHz core clock
// Notes:   Times in ms as printed, counts derived where used
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

`define I2C_ADDR 7'h40
`define CMD_T_HOLD 8'hE3
`define CMD_RH_HOLD 8'hE5
`define CMD_T_POLL 8'hF3
`define CMD_RH_POLL 8'hF5
`define CMD_WR_CFG 8'hE6
`define CMD_RD_CFG 8'hE7
`define CMD_SOFT_RST 8'hFE

`define CFG_RESET 8'h02
`define CFG_RES_HI 7
`define CFG_LOW_SUPPLY 6
`define CFG_HEATER 2
`define CFG_NO_RELOAD 1
`define CFG_RES_LO 0

`define CRC_POLY 8'h31
`define CRC_INIT 8'h00

`define CLK_PERIOD_NS 40
`define MS_NS 1000000
`define CYCLES_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define STARTUP_MS 15
`define SOFT_RESET_MS 15
`define T14_MS 85
`define T13_MS 43
`define T12_MS 22
`define T11_MS 11
`define H12_MS 29
`define H11_MS 15
`define H10_MS 9
`define H8_MS 4

`endif

/* File: hw/sensor_pkg.sv */
// Purpose: Types shared by the command slave
// Assumes: Nothing
// Notes:   Constants live in sensor_consts.svh
`default_nettype none
package sensor_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_HACK, ST_STRETCH} state_t;
  typedef enum logic [1:0] {P_ADDR, P_CMD, P_WDATA, P_DONE} purpose_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_REG, SRC_MEAS} rd_src_t;
endpackage
`default_nettype wire

/* File: sim/cmd_slave_properties.sv */
// Purpose: Port assertions of the command slave
// Assumes: Core clock domain only
// Notes: Counters bound the long spans
`timescale 1ns/1ps
`default_nettype none
module cmd_slave_properties #(
  parameter int CYCLES_PER_MS = 25000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_low_supply,
  input wire logic [13:0] i_conv_result,
  input wire logic o_conv_busy,
  input wire logic o_conv_humidity,
  input wire logic o_heater_en
);
  logic [31:0] up_ff, nxt_up, bz_ff, nxt_bz;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_up = i_rst ? 32'h0 : (up_ff < 32'(15 * CYCLES_PER_MS)) ? up_ff + 32'h1 : up_ff;
    nxt_bz = (i_rst || !o_conv_busy) ? 32'h0 : bz_ff + 32'h1;
  end
  always_ff @(posedge i_core_clk)
  begin
    up_ff <= nxt_up;
    bz_ff <= nxt_bz;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_idle_out;
    $fell(i_rst) |-> !o_sda_oe && !o_scl_oe && !o_conv_busy && !o_heater_en;
  endproperty
  a_idle_out: assert property (p_idle_out)
    else $error("outputs active after reset");
  property p_deaf;
    up_ff < 32'(15 * CYCLES_PER_MS) |-> !o_sda_oe;
  endproperty
  a_deaf: assert property (p_deaf)
    else $error("acknowledge during start-up");
  property p_open_drain;
    o_sda_out == 1'h0 && o_scl_out == 1'h0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain data not low");
  property p_stretch_busy;
    $rose(o_scl_oe) |-> o_conv_busy;
  endproperty
  a_stretch_busy: assert property (p_stretch_busy)
    else $error("clock held without conversion");
  property p_stretch_end;
    $fell(o_conv_busy) |-> ##[0:2] !o_scl_oe;
  endproperty
  a_stretch_end: assert property (p_stretch_end)
    else $error("clock still held after conversion");
  property p_busy_max;
    bz_ff <= 32'(85 * CYCLES_PER_MS + 1);
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("conversion too long");
  property p_busy_min;
    $fell(o_conv_busy) |-> bz_ff >= 32'(4 * CYCLES_PER_MS - 1);
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("conversion too short");
  property p_type;
    o_conv_busy && $past(o_conv_busy) |-> $stable(o_conv_humidity);
  endproperty
  a_type: assert property (p_type)
    else $error("type changed in conversion");
  c_stretch: cover property ($rose(o_scl_oe));
  c_hum: cover property ($fell(o_conv_busy) && o_conv_humidity);
  c_ack: cover property ($rose(o_sda_oe));
endmodule // cmd_slave_properties
bind humidity_temp_i2c_command_slave cmd_slave_properties #(
  .CYCLES_PER_MS(CYCLES_PER_MS)
) u_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(i_scl), .o_scl_out(o_scl_out),
  .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .i_low_supply(i_low_supply), .i_conv_result(i_conv_result), .o_conv_busy(o_conv_busy),
  .o_conv_humidity(o_conv_humidity), .o_heater_en(o_heater_en)
);
`default_nettype wire

/* File: sim/i2c_host_model.sv */
// Purpose: Bus master model on the far side
// Assumes: 320 ns bit period, 4 cycles low and high
// Notes: Drives only low; lines are pulled up
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  int stuck_cnt = 0;
  initial
  begin
    o_scl_oe = 1'h0;
    o_sda_oe = 1'h0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Bounded wait: slave may hold the clock
  task automatic rel;
    int n;
    n = 0;
    o_scl_oe = 1'h0;
    #1;
    while (!i_scl && n < 4000)
    begin
      @(negedge i_clk);
      n++;
    end
    // Counted so the bench can fail a clock that is never released
    if (!i_scl)
      stuck_cnt++;
  endtask
  task automatic bit_io(input logic b, output logic r);
    hc(1);
    o_sda_oe = !b;
    hc(3);
    rel();
    hc(4);
    r = i_sda;
    o_scl_oe = 1'h1;
  endtask
  // Also serves as repeated start
  task automatic start;
    hc(1);
    o_sda_oe = 1'h0;
    hc(5);
    rel();
    hc(4);
    o_sda_oe = 1'h1;
    hc(4);
    o_scl_oe = 1'h1;
  endtask
  task automatic stop;
    hc(1);
    o_sda_oe = 1'h1;
    hc(5);
    rel();
    hc(4);
    o_sda_oe = 1'h0;
    hc(4);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'h1, d[i]);
    bit_io(nak, r);
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench of the command slave
// Assumes: 1 ms scaled to 10 cycles
// Notes: Wire level is the and of both open drains
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CPM = 10;
  logic clk, rst, low, h_scl, h_sda, scl_oe, sda_oe, busy, hum, heat, scl, sda;
  logic [13:0] conv;
  int error_cnt = 0;
  int n_compared = 0;
  assign scl = !(scl_oe | h_scl);
  assign sda = !(sda_oe | h_sda);
  humidity_temp_i2c_command_slave #(.CYCLES_PER_MS(CPM)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_scl(scl), .o_scl_out(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe), .i_low_supply(low),
    .i_conv_result(conv), .o_conv_busy(busy), .o_conv_humidity(hum), .o_heater_en(heat)
  );
  i2c_host_model host (
    .i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(h_scl), .o_sda_oe(h_sda)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ d[i]) ? {c[6:0], 1'h0} ^ 8'h31 : {c[6:0], 1'h0};
    return c;
  endfunction
  task automatic send(input logic [7:0] b, input logic e, input string s);
    logic a;
    host.wr_byte(b, a);
    check(s, {15'h0, a}, {15'h0, e});
  endtask
  task automatic cmd(input logic [7:0] c);
    host.start();
    send(8'h80, 1'h1, "addr");
    send(c, 1'h1, "cmd");
  endtask
  task automatic rd(input int n, output logic [23:0] v);
    logic [7:0] b;
    v = 24'h0;
    for (int i = 0; i < n; i++)
    begin
      host.rd_byte(i == n - 1, b);
      v = {v[15:0], b};
    end
  endtask
  task automatic cfg_rd(input logic [7:0] e);
    logic [23:0] v;
    cmd(8'hE7);
    host.start();
    send(8'h81, 1'h1, "cfg hdr");
    rd(1, v);
    host.stop();
    check("cfg", {8'h0, v[7:0]}, {8'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial
  begin : main
    logic [23:0] v;
    logic a;
    int n;
    rst = 1'h1;
    low = 1'h0;
    conv = 14'h18D5;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    host.start();
    send(8'h80, 1'h0, "early addr");
    host.stop();
    repeat (15 * CPM) @(negedge clk);
    host.start();
    send(8'h82, 1'h0, "foreign addr");
    host.stop();
    cfg_rd(8'h02);
    // Reserved bits written back as read; bit 6 is read-only
    cmd(8'hE6);
    send(8'hC7, 1'h1, "cfg data");
    host.stop();
    check("heater", {15'h0, heat}, 16'h1);
    cfg_rd(8'h87);
    low = 1'h1;
    cmd(8'hE3);
    host.start();
    send(8'h81, 1'h1, "hold hdr");
    rd(3, v);
    host.stop();
    check("t res", v[23:8], {conv, 2'h0});
    check("t crc", {8'h0, v[7:0]}, {8'h0, crc8({conv, 2'h0})});
    cfg_rd(8'hC7);
    conv = 14'h2A3C;
    cmd(8'hF5);
    repeat (10) @(negedge clk);
    host.stop();
    check("poll busy", {15'h0, busy}, 16'h1);
    check("rh type", {15'h0, hum}, 16'h1);
    host.start();
    send(8'h81, 1'h0, "busy poll");
    host.stop();
    a = 1'h0;
    n = 0;
    while (!a && n < 50)
    begin
      host.start();
      host.wr_byte(8'h81, a);
      if (!a)
        host.stop();
      n++;
    end
    check("poll ack", {15'h0, a}, 16'h1);
    rd(2, v);
    repeat (6) @(negedge clk);
    check("no crc", {15'h0, sda_oe}, 16'h0);
    host.stop();
    check("rh res", v[15:0], {conv, 2'h2});
    cmd(8'hFE);
    host.stop();
    host.start();
    send(8'h80, 1'h0, "addr in reset");
    host.stop();
    repeat (15 * CPM) @(negedge clk);
    check("heater kept", {15'h0, heat}, 16'h1);
    cfg_rd(8'h06);
    // Reload on: defaults return before the conversion, so 14-bit timing
    cmd(8'hE6);
    send(8'h05, 1'h1, "reload cfg");
    host.stop();
    cmd(8'hF3);
    host.stop();
    check("t type", {15'h0, hum}, 16'h0);
    n = 0;
    while (busy && n < 100 * CPM)
    begin
      @(negedge clk);
      n++;
    end
    check("t14 time", {15'h0, (n > 80 * CPM) && (n <= 85 * CPM)}, 16'h1);
    cfg_rd(8'h46);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    check("heater reset", {15'h0, heat}, 16'h0);
    repeat (15 * CPM + 4) @(negedge clk);
    cfg_rd(8'h02);
    check("scl stuck", 16'(host.stuck_cnt), 16'h0);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
